// file: rtl/fspg_consts.svh
// Purpose: offsets, bit positions, reset values and counts of the flash self-program guard
// Assumes: byte-wide register port, word addresses of 16 bits
// Notes:   definitions only
`ifndef FSPG_CONSTS_SVH
`define FSPG_CONSTS_SVH

`define FSPG_CTRL_OFS     8'h00
`define FSPG_LOCK_OFS     8'h04
`define FSPG_STAT_OFS     8'h08

`define FSPG_CTRL_EN      0
`define FSPG_CTRL_ERASE   1
`define FSPG_CTRL_WRITE   2
`define FSPG_CTRL_LOCKSET 3
`define FSPG_CTRL_READEN  4
`define FSPG_CTRL_BUSY    6

`define FSPG_STAT_ACTIVE  0
`define FSPG_STAT_REFUSED 1
`define FSPG_STAT_HALT    2

`define FSPG_LOCK_RESET   4'hf
`define FSPG_ARM_CYCLES   3'h4

`endif

// file: rtl/fspg_pkg.sv
// Purpose: types shared by the flash self-program guard files
// Assumes: 16-bit word address and data on the store path
// Notes:   constants live in fspg_consts.svh
package fspg_pkg;

  typedef enum logic [1:0] {
    FSPG_IDLE,
    FSPG_ARMED,
    FSPG_OP
  } fspg_state_type;

  typedef enum logic [2:0] {
    FSPG_CMD_NONE,
    FSPG_CMD_BUFLOAD,
    FSPG_CMD_ERASE,
    FSPG_CMD_WRITE,
    FSPG_CMD_LOCKSET,
    FSPG_CMD_READEN
  } fspg_cmd_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } fspg_store_type;

  // [1] is the high bit of each field, [0] the low bit
  typedef struct packed {
    logic [1:0] boot;
    logic [1:0] app;
  } fspg_lock_type;

endpackage : fspg_pkg

// file: rtl/fspg_lock_store.sv
// Purpose: holds the application and boot lock fields
// Assumes: a programmed bit is 0, an unprogrammed bit is 1
// Notes:   programming only clears bits; only full erase sets them back
`timescale 1ns/1ps
`include "fspg_consts.svh"
module fspg_lock_store #(
  parameter int unsigned LOCK_W = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  progEn,
  input  wire fspg_pkg::fspg_lock_type progData,
  input  wire logic                  eraseAll,
  output fspg_pkg::fspg_lock_type      lockQ
);

  generate
    if (LOCK_W != $bits(fspg_pkg::fspg_lock_type)) begin : g_bad_width
      $error("fspg_lock_store: LOCK_W must match the lock field layout");
    end
  endgenerate

  localparam logic [LOCK_W-1:0] LOCK_RST = LOCK_W'(`FSPG_LOCK_RESET);

  logic [LOCK_W-1:0] lockBits;

  // reset stands for a fresh part; a real array keeps its bits over reset
  genvar i;
  generate
    for (i = 0; i < LOCK_W; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          lockBits[i] <= LOCK_RST[i];
        end else if (eraseAll) begin
          lockBits[i] <= 1'b1;
        end else if (progEn && !progData[i]) begin
          lockBits[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign lockQ = fspg_pkg::fspg_lock_type'(lockBits);

endmodule : fspg_lock_store

// file: rtl/fspg_guard.sv
// Purpose: section and lock guard for flash self-programming by the cpu
// Assumes: cpu strobes synchronous to clk_sys; flash array reports completion
// Notes:   load data come from a combinational array read in the request cycle
`timescale 1ns/1ps
`include "fspg_consts.svh"
//
// Contract
// - flash split into fixed rww and halting regions
// - classify by target page, not fetch region
// - rww target keeps cpu running
// - halting target stalls cpu, nothing readable
// - rww region unreadable during programming
// - busy flag reads one while rww blocked
// - rww stays blocked until software clears flag
// - boot section lies wholly in halting region
// - two independent lock fields, application and boot
// - locks only cleared by full chip erase
// - general write lock ignores store ops (no general lock here; execGo never consults one)
// - general read/write lock ignores load/store (no general lock here; loadDeny has no such term)
// - application lock modes gate stores and loads
// - boot lock modes gate stores and loads
// - app locks 3/4 mask irqs in app
// - boot locks 3/4 mask irqs in boot
// - store ops from application section ignored
// - busy clears on read enable or buffer load
module fspg_guard #(
  parameter int unsigned RWW_LIMIT  = 16'h0c00,
  parameter int unsigned BOOT_START = 16'h0f00
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWrData,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic [7:0]                  regRdData,
  input  wire logic                   storeReq,
  input  wire fspg_pkg::fspg_store_type storeOp,
  input  wire logic                   fetchFromBoot,
  input  wire logic                   vectorsInBoot,
  input  wire logic                   loadReq,
  input  wire logic [15:0]            loadAddr,
  input  wire logic [15:0]            flashRdData,
  input  wire logic                   flashDone,
  input  wire logic                   extLockWr,
  input  wire fspg_pkg::fspg_lock_type  extLockData,
  input  wire logic                   chipErase,
  output logic                        cpuHalt,
  output logic                        rwwBlocked,
  output logic                        flashCmdValid,
  output fspg_pkg::fspg_cmd_type        flashCmd,
  output fspg_pkg::fspg_store_type      flashOp,
  output logic                        loadValid,
  output logic                        loadDenied,
  output logic [15:0]                 loadData,
  output logic                        irqSuppress,
  output logic                        storeRefused
);

  localparam logic [15:0] RWW_LIM_W  = 16'(RWW_LIMIT);
  localparam logic [15:0] BOOT_STA_W = 16'(BOOT_START);

  // the boot section must never reach into the rww region
  generate
    if (BOOT_START < RWW_LIMIT || BOOT_START > 16'hffff || RWW_LIMIT == 0) begin : g_bad_bounds
      $error("fspg_guard: boot start must lie in the halting region");
    end
  endgenerate

  fspg_pkg::fspg_state_type state;
  fspg_pkg::fspg_cmd_type   cmd;
  fspg_pkg::fspg_lock_type  lockQ;
  fspg_pkg::fspg_cmd_type   newCmd;
  fspg_pkg::fspg_lock_type  lockPgmData;
  logic [2:0]               armCnt;
  logic                     refusedSticky;
  logic                     ctrlWr;
  logic                     statWr;
  logic                     execGo;
  logic                     isProg;
  logic                     progRefused;
  logic                     progStart;
  logic                     lockPgm;
  logic                     loadDeny;

  // fixed split, independent of where the boot section starts
  function automatic logic inHalting(input logic [15:0] a);
    return a >= RWW_LIM_W;
  endfunction : inHalting

  function automatic logic inBoot(input logic [15:0] a);
    return a >= BOOT_STA_W;
  endfunction : inBoot

  // low bit programmed blocks stores into the section it guards
  function automatic logic storeLocked(input fspg_pkg::fspg_lock_type l,
                                       input logic [15:0] a);
    return inBoot(a) ? !l.boot[0] : !l.app[0];
  endfunction : storeLocked

  // high bit programmed blocks loads that cross from the other section
  function automatic logic loadLocked(input fspg_pkg::fspg_lock_type l,
                                      input logic [15:0] a,
                                      input logic fromBoot);
    return inBoot(a) ? (!fromBoot && !l.boot[1]) : (fromBoot && !l.app[1]);
  endfunction : loadLocked

  function automatic fspg_pkg::fspg_cmd_type decodeCmd(input logic [4:0] b);
    fspg_pkg::fspg_cmd_type c;
    c = fspg_pkg::FSPG_CMD_NONE;
    unique case (b)
      5'h01:   c = fspg_pkg::FSPG_CMD_BUFLOAD;
      5'h03:   c = fspg_pkg::FSPG_CMD_ERASE;
      5'h05:   c = fspg_pkg::FSPG_CMD_WRITE;
      5'h09:   c = fspg_pkg::FSPG_CMD_LOCKSET;
      5'h11:   c = fspg_pkg::FSPG_CMD_READEN;
      default: c = fspg_pkg::FSPG_CMD_NONE;
    endcase
    return c;
  endfunction : decodeCmd

  function automatic logic [4:0] cmdBits(input fspg_pkg::fspg_cmd_type c);
    logic [4:0] b;
    b = 5'h00;
    unique case (c)
      fspg_pkg::FSPG_CMD_NONE:    b = 5'h00;
      fspg_pkg::FSPG_CMD_BUFLOAD: b = 5'h01;
      fspg_pkg::FSPG_CMD_ERASE:   b = 5'h03;
      fspg_pkg::FSPG_CMD_WRITE:   b = 5'h05;
      fspg_pkg::FSPG_CMD_LOCKSET: b = 5'h09;
      fspg_pkg::FSPG_CMD_READEN:  b = 5'h11;
      default:                    b = 5'h00;
    endcase
    return b;
  endfunction : cmdBits

  always_comb begin
    ctrlWr      = regWr && (regAddr == `FSPG_CTRL_OFS);
    statWr      = regWr && (regAddr == `FSPG_STAT_OFS);
    newCmd      = decodeCmd(regWrData[4:0]);
    // only boot code may start anything; the general memory lock is not consulted
    execGo      = (state == fspg_pkg::FSPG_ARMED) && storeReq && fetchFromBoot;
    isProg      = (cmd == fspg_pkg::FSPG_CMD_ERASE) || (cmd == fspg_pkg::FSPG_CMD_WRITE);
    progRefused = execGo && isProg && storeLocked(lockQ, storeOp.addr);
    progStart   = execGo && isProg && !progRefused;
    lockPgm     = extLockWr || (execGo && cmd == fspg_pkg::FSPG_CMD_LOCKSET);
    lockPgmData = extLockWr ? extLockData : fspg_pkg::fspg_lock_type'(storeOp.data[3:0]);
    // general read/write lock is likewise not a term here
    loadDeny    = cpuHalt
                  || (rwwBlocked && !inHalting(loadAddr))
                  || loadLocked(lockQ, loadAddr, fetchFromBoot);
  end

  fspg_lock_store #(
    .LOCK_W (4)
  ) u_locks (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .progEn   (lockPgm),
    .progData (lockPgmData),
    .eraseAll (chipErase),
    .lockQ    (lockQ)
  );

  // command sequencer: armed window, then one store op or timeout
  always_ff @(posedge clk_sys) begin : seq
    if (rst) begin
      state  <= fspg_pkg::FSPG_IDLE;
      cmd    <= fspg_pkg::FSPG_CMD_NONE;
      armCnt <= 3'h0;
    end else begin
      unique case (state)
        fspg_pkg::FSPG_IDLE: begin
          if (ctrlWr && newCmd != fspg_pkg::FSPG_CMD_NONE) begin
            state  <= fspg_pkg::FSPG_ARMED;
            cmd    <= newCmd;
            armCnt <= `FSPG_ARM_CYCLES - 3'h1;
          end
        end
        fspg_pkg::FSPG_ARMED: begin
          if (progStart) begin
            state <= fspg_pkg::FSPG_OP;
          end else if (execGo || armCnt == 3'h0) begin
            state <= fspg_pkg::FSPG_IDLE;
            cmd   <= fspg_pkg::FSPG_CMD_NONE;
          end else begin
            armCnt <= armCnt - 3'h1;
          end
        end
        fspg_pkg::FSPG_OP: begin
          if (flashDone) begin
            state <= fspg_pkg::FSPG_IDLE;
            cmd   <= fspg_pkg::FSPG_CMD_NONE;
          end
        end
      endcase
    end
  end

  // busy flag: set by an rww-targeted op, cleared only by software action
  always_ff @(posedge clk_sys) begin : busy
    if (rst) begin
      rwwBlocked <= 1'b0;
    end else if (progStart && !inHalting(storeOp.addr)) begin
      rwwBlocked <= 1'b1;
    end else if (execGo && (cmd == fspg_pkg::FSPG_CMD_READEN ||
                            cmd == fspg_pkg::FSPG_CMD_BUFLOAD)) begin
      rwwBlocked <= 1'b0;
    end
  end

  // halt only for halting-region targets, and for the whole op
  always_ff @(posedge clk_sys) begin : halt
    if (rst) begin
      cpuHalt <= 1'b0;
    end else if (progStart && inHalting(storeOp.addr)) begin
      cpuHalt <= 1'b1;
    end else if (state == fspg_pkg::FSPG_OP && flashDone) begin
      cpuHalt <= 1'b0;
    end
  end

  // refused ops never reach the array
  always_ff @(posedge clk_sys) begin : flash_cmd
    if (rst) begin
      flashCmdValid <= 1'b0;
      flashCmd      <= fspg_pkg::FSPG_CMD_NONE;
      flashOp       <= '0;
    end else begin
      flashCmdValid <= progStart || (execGo && cmd == fspg_pkg::FSPG_CMD_BUFLOAD);
      if (execGo) begin
        flashCmd <= cmd;
        flashOp  <= storeOp;
      end
    end
  end

  always_ff @(posedge clk_sys) begin : refuse
    if (rst) begin
      storeRefused  <= 1'b0;
      refusedSticky <= 1'b0;
    end else begin
      storeRefused <= progRefused || (storeReq && !fetchFromBoot);
      // a new refusal wins over a clear in the same cycle
      if (progRefused || (storeReq && !fetchFromBoot)) begin
        refusedSticky <= 1'b1;
      end else if (statWr && regWrData[`FSPG_STAT_REFUSED]) begin
        refusedSticky <= 1'b0;
      end
    end
  end

  // protected words are replaced by zero, never passed through
  always_ff @(posedge clk_sys) begin : load_path
    if (rst) begin
      loadValid  <= 1'b0;
      loadDenied <= 1'b0;
      loadData   <= 16'h0000;
    end else begin
      loadValid  <= loadReq;
      loadDenied <= loadReq && loadDeny;
      loadData   <= (loadReq && !loadDeny) ? flashRdData : 16'h0000;
    end
  end

  always_ff @(posedge clk_sys) begin : irq_gate
    if (rst) begin
      irqSuppress <= 1'b0;
    end else begin
      irqSuppress <= (vectorsInBoot && !fetchFromBoot && !lockQ.app[1])
                     || (!vectorsInBoot && fetchFromBoot && !lockQ.boot[1]);
    end
  end

  always_ff @(posedge clk_sys) begin : reg_read
    if (rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= 8'h00;
      if (regRd) begin
        unique case (regAddr)
          `FSPG_CTRL_OFS: begin
            regRdData <= {1'b0, rwwBlocked, 1'b0, cmdBits(cmd)};
          end
          `FSPG_LOCK_OFS: begin
            regRdData <= {4'h0, lockQ};
          end
          `FSPG_STAT_OFS: begin
            regRdData <= {5'h00, cpuHalt, refusedSticky, state == fspg_pkg::FSPG_OP};
          end
          default: begin
            regRdData <= 8'h00;
          end
        endcase
      end
    end
  end

  halt_on_halting_region_a: assert property (@(posedge clk_sys) disable iff (rst)
    progStart && inHalting(storeOp.addr) |=> cpuHalt && flashCmdValid && $stable(rwwBlocked))
    else $error("halting-region op did not halt the cpu");

  rww_runs_a: assert property (@(posedge clk_sys) disable iff (rst)
    progStart && !inHalting(storeOp.addr) |=> !cpuHalt && rwwBlocked)
    else $error("rww op halted the cpu or did not block the region");

  halt_holds_a: assert property (@(posedge clk_sys) disable iff (rst)
    cpuHalt && !flashDone |=> cpuHalt)
    else $error("cpu released before the op finished");

  busy_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(rwwBlocked) |-> $past(execGo) && ($past(cmd) == fspg_pkg::FSPG_CMD_READEN ||
                                            $past(cmd) == fspg_pkg::FSPG_CMD_BUFLOAD))
    else $error("busy flag cleared without software action");

  app_store_ignored_a: assert property (@(posedge clk_sys) disable iff (rst)
    storeReq && !fetchFromBoot |=> storeRefused && !flashCmdValid)
    else $error("store from application section was acted on");

  store_lock_a: assert property (@(posedge clk_sys) disable iff (rst)
    execGo && isProg && storeLocked(lockQ, storeOp.addr) |=> !flashCmdValid ##1 !cpuHalt)
    else $error("locked section was programmed");

  rww_load_deny_a: assert property (@(posedge clk_sys) disable iff (rst)
    loadReq && rwwBlocked && !inHalting(loadAddr) |=> loadDenied && loadData == 16'h0000)
    else $error("rww data delivered while blocked");

  irq_mask_a: assert property (@(posedge clk_sys) disable iff (rst)
    vectorsInBoot && !fetchFromBoot && !lockQ.app[1] |=> irqSuppress)
    else $error("interrupt not suppressed under application lock");

  irq_boot_a: assert property (@(posedge clk_sys) disable iff (rst)
    !vectorsInBoot && fetchFromBoot && !lockQ.boot[1] |=> irqSuppress)
    else $error("interrupt not suppressed under boot lock");

  lock_erase_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    (|(lockQ & ~$past(lockQ))) |-> $past(chipErase))
    else $error("lock bit returned to unprogrammed without erase");

endmodule : fspg_guard

// file: sim/fspg_flash_model.sv
// Purpose: flash array model answering the guard's commands
// Assumes: erase and write take DONE_LAT cycles, other commands finish at once
// Notes:   read data are an address pattern, zero only at address 16'ha5c3, so a leak shows
`timescale 1ns/1ps
module fspg_flash_model #(
  parameter int DONE_LAT = 6
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   flashCmdValid,
  input  wire fspg_pkg::fspg_cmd_type flashCmd,
  input  wire logic [15:0]            loadAddr,
  output logic [15:0]                 flashRdData,
  output logic                        flashDone
);
  int count;

  assign flashRdData = loadAddr ^ 16'ha5c3;

  always_ff @(posedge clk_sys) begin
    flashDone <= 1'h0;
    if (rst) begin
      count <= 0;
    end else if (flashCmdValid && (flashCmd == fspg_pkg::FSPG_CMD_ERASE ||
                 flashCmd == fspg_pkg::FSPG_CMD_WRITE)) begin
      count <= DONE_LAT;
    end else if (count == 1) begin
      count     <= 0;
      flashDone <= 1'h1;
    end else if (count > 1) begin
      count <= count - 1;
    end
  end
endmodule : fspg_flash_model

// file: sim/tb.sv
// Purpose: self-checking bench of the flash self-program guard
// Assumes: default region and boot boundaries, lock register reads {boot,app}
// Notes:   a 0 lock bit is programmed; boundary pages sit on both sides
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] RWW_PG  = 16'h0100;
  localparam logic [15:0] HALT_PG = 16'h0c00;
  localparam logic [15:0] BOOT_PG = 16'h0f00;
  logic                     clk_sys, rst, regWr, regRd, storeReq, fetchFromBoot;
  logic                     vectorsInBoot, loadReq, flashDone, extLockWr, chipErase;
  logic                     cpuHalt, rwwBlocked, flashCmdValid, loadValid, loadDenied;
  logic                     irqSuppress, storeRefused;
  logic [7:0]               regAddr, regWrData, regRdData;
  logic [15:0]              loadAddr, flashRdData, loadData;
  fspg_pkg::fspg_store_type storeOp, flashOp;
  fspg_pkg::fspg_lock_type  extLockData;
  fspg_pkg::fspg_cmd_type   flashCmd;
  int                       fail_count, samples_checked;

  fspg_guard fspg_guard_inst (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .storeReq(storeReq), .storeOp(storeOp), .fetchFromBoot(fetchFromBoot),
    .vectorsInBoot(vectorsInBoot), .loadReq(loadReq), .loadAddr(loadAddr),
    .flashRdData(flashRdData), .flashDone(flashDone), .extLockWr(extLockWr),
    .extLockData(extLockData), .chipErase(chipErase), .cpuHalt(cpuHalt),
    .rwwBlocked(rwwBlocked), .flashCmdValid(flashCmdValid), .flashCmd(flashCmd),
    .flashOp(flashOp), .loadValid(loadValid), .loadDenied(loadDenied),
    .loadData(loadData), .irqSuppress(irqSuppress), .storeRefused(storeRefused));

  fspg_flash_model fspg_flash_model_inst (.clk_sys(clk_sys), .rst(rst),
    .flashCmdValid(flashCmdValid), .flashCmd(flashCmd), .loadAddr(loadAddr),
    .flashRdData(flashRdData), .flashDone(flashDone));

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'h1;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1 q = regRdData;
  endtask : reg_read

  // arm then issue the store two edges later, inside the arm window
  task automatic store_program_op(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d,
                     input logic boot);
    reg_write(8'h00, c);
    @(posedge clk_sys);
    storeOp       <= '{addr: a, data: d};
    fetchFromBoot <= boot;
    storeReq      <= 1'h1;
    @(posedge clk_sys);
    storeReq <= 1'h0;
    #1;
  endtask : store_program_op

  task automatic load(input logic [15:0] a, input logic boot, input logic denied);
    @(posedge clk_sys);
    loadAddr      <= a;
    fetchFromBoot <= boot;
    loadReq       <= 1'h1;
    @(posedge clk_sys);
    loadReq <= 1'h0;
    #1 check({loadValid, loadDenied}, {1'h1, denied});
    check(loadData, denied ? 16'h0000 : (a ^ 16'ha5c3));
  endtask : load

  task automatic lock_pulse(input logic wr, input logic erase, input logic [3:0] d);
    @(posedge clk_sys);
    extLockWr   <= wr;
    chipErase   <= erase;
    extLockData <= d;
    @(posedge clk_sys);
    extLockWr <= 1'h0;
    chipErase <= 1'h0;
  endtask : lock_pulse

  task automatic wait_done;
    int n;
    n = 0;
    while (flashDone !== 1'h1 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= 100) begin
      fail_count++;
      $display("ERROR %0t: flash never finished", $time);
      print_verdict();
    end else begin
      @(posedge clk_sys);
      #1;
    end
  endtask : wait_done

  task automatic irq_check(input logic vib, input logic fb, input logic exp);
    @(posedge clk_sys);
    vectorsInBoot <= vib;
    fetchFromBoot <= fb;
    @(posedge clk_sys);
    #1 check(irqSuppress, exp);
  endtask : irq_check

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    logic [7:0] q;
    fail_count = 0;
    samples_checked = 0;
    {rst, regWr, regRd, storeReq, fetchFromBoot, vectorsInBoot} = 6'h20;
    {loadReq, extLockWr, chipErase} = 3'h0;
    {regAddr, regWrData, loadAddr} = 32'h0;
    storeOp = '0;
    extLockData = 4'hf;
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    reg_read(8'h00, q);
    check(q, 8'h00);
    reg_read(8'h04, q);
    check(q, 8'h0f);
    reg_read(8'h0c, q);
    check(q, 8'h00);
    // stores from application code never reach the array
    store_program_op(8'h03, RWW_PG, 16'h0000, 1'h0);
    check({flashCmdValid, storeRefused}, 2'h1);
    // the status read also lets the unused arm window lapse
    reg_read(8'h08, q);
    check(q, 8'h02);
    reg_write(8'h08, 8'h02);
    reg_read(8'h08, q);
    check(q, 8'h00);
    store_program_op(8'h03, RWW_PG, 16'h0000, 1'h1);
    check({flashCmdValid, cpuHalt, rwwBlocked}, 3'h5);
    check(flashCmd, fspg_pkg::FSPG_CMD_ERASE);
    load(HALT_PG, 1'h1, 1'h0);
    load(HALT_PG - 16'h0001, 1'h1, 1'h1);
    reg_read(8'h00, q);
    check(q[6], 1'h1);
    wait_done();
    check(rwwBlocked, 1'h1);
    load(RWW_PG, 1'h1, 1'h1);
    // software re-enables the region before touching it again
    store_program_op(8'h11, RWW_PG, 16'h0000, 1'h1);
    check(rwwBlocked, 1'h0);
    load(RWW_PG, 1'h1, 1'h0);
    store_program_op(8'h05, HALT_PG, 16'h0000, 1'h1);
    check({flashCmdValid, cpuHalt}, 2'h3);
    check(flashCmd, fspg_pkg::FSPG_CMD_WRITE);
    reg_read(8'h08, q);
    check(q, 8'h05);
    load(BOOT_PG, 1'h1, 1'h1);
    wait_done();
    check(cpuHalt, 1'h0);
    store_program_op(8'h03, RWW_PG, 16'h0000, 1'h1);
    wait_done();
    store_program_op(8'h01, RWW_PG, 16'h1234, 1'h1);
    check({rwwBlocked, flashOp.data}, {1'h0, 16'h1234});
    // application write-protect only
    lock_pulse(1'h1, 1'h0, {2'h3, 2'h2});
    store_program_op(8'h03, RWW_PG, 16'h0000, 1'h1);
    check({flashCmdValid, storeRefused}, 2'h1);
    store_program_op(8'h03, BOOT_PG, 16'h0000, 1'h1);
    check(flashCmdValid, 1'h1);
    wait_done();
    // boot mode 3 programmed by software
    store_program_op(8'h09, 16'h0000, {12'h000, 2'h0, 2'h2}, 1'h1);
    reg_read(8'h04, q);
    check(q, 8'h02);
    load(BOOT_PG, 1'h0, 1'h1);
    load(BOOT_PG - 16'h0001, 1'h0, 1'h0);
    load(BOOT_PG, 1'h1, 1'h0);
    store_program_op(8'h03, BOOT_PG, 16'h0000, 1'h1);
    check({flashCmdValid, storeRefused}, 2'h1);
    irq_check(1'h0, 1'h1, 1'h1);
    irq_check(1'h0, 1'h0, 1'h0);
    lock_pulse(1'h1, 1'h0, 4'hf);
    reg_read(8'h04, q);
    check(q, 8'h02);
    lock_pulse(1'h0, 1'h1, 4'hf);
    reg_read(8'h04, q);
    check(q, 8'h0f);
    // application mode 4: loads blocked, stores allowed
    lock_pulse(1'h1, 1'h0, {2'h3, 2'h1});
    load(RWW_PG, 1'h1, 1'h1);
    store_program_op(8'h03, RWW_PG, 16'h0000, 1'h1);
    check({flashCmdValid, storeRefused}, 2'h2);
    wait_done();
    irq_check(1'h1, 1'h0, 1'h1);
    irq_check(1'h1, 1'h1, 1'h0);
    print_verdict();
  end
endmodule : tb
